// ### icp_pkg.sv
package icp_pkg;

  // Register byte addresses on the Wishbone slave.
  localparam logic [7:0] ICP_ADR_HV_CTRL = 8'h00;
  localparam logic [7:0] ICP_ADR_FP_CTRL = 8'h04;
  localparam logic [7:0] ICP_ADR_STATUS  = 8'h08;

  // Reset values of the control registers; the fast pair starts in full-rate clocking.
  localparam logic [31:0] ICP_HV_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ICP_FP_CTRL_RST = 32'h0000_8000;

  // Data widths of the two cells.
  localparam int unsigned ICP_HV_W    = 2;
  localparam int unsigned ICP_FP_W    = 4;
  localparam int unsigned ICP_CELLS   = 2;
  localparam int unsigned ICP_CELL_HV = 0;
  localparam int unsigned ICP_CELL_FP = 1;

  // Dynamic input delay: 64 steps held in a 6-bit counter.
  localparam int unsigned ICP_DELAY_W     = 6;
  localparam int unsigned ICP_DELAY_STEPS = 64;
  localparam logic [5:0]  ICP_DELAY_RST   = 6'h00;
  localparam logic [5:0]  ICP_DELAY_MAX   = 6'h3f;
  localparam logic [5:0]  ICP_DELAY_MIN   = 6'h00;

  // Field layout of the control registers.
  localparam int unsigned ICP_CELL_CTRL_W = 10;
  localparam int unsigned ICP_FP_EXT_LSB  = 10;
  localparam int unsigned ICP_FP_EXT_W    = 6;

  // Field layout of the status register.
  localparam int unsigned ICP_ST_HV_IN_LSB = 0;
  localparam int unsigned ICP_ST_FP_IN_LSB = 4;
  localparam int unsigned ICP_ST_FP_N_BIT  = 8;
  localparam int unsigned ICP_ST_DELAY_LSB = 16;

  // Bit positions in the synchroniser bundle.
  localparam int unsigned ICP_SY_RX_REG = 0;
  localparam int unsigned ICP_SY_TX_REG = 1;
  localparam int unsigned ICP_SY_RX_SER = 2;
  localparam int unsigned ICP_SY_TX_SER = 3;
  localparam int unsigned ICP_SY_HV_PAD = 4;
  localparam int unsigned ICP_SY_FP_P   = 5;
  localparam int unsigned ICP_SY_FP_N   = 6;
  localparam int unsigned ICP_SY_W      = 7;

  // Serializer bit index.
  localparam logic [1:0] ICP_SER_FIRST = 2'h0;
  localparam logic [1:0] ICP_SER_NEXT  = 2'h1;

  // Destinations of the fast-pair unregistered tap.
  typedef enum logic [2:0] {
    ICP_DEST_GCLK,
    ICP_DEST_RCLK,
    ICP_DEST_PLL_REF,
    ICP_DEST_PLL_FB,
    ICP_DEST_VREF
  } icp_dest_t;

  localparam int unsigned ICP_DEST_N = 5;

  // Per-cell path options; in_reg_en is bit 0 of the control word.
  typedef struct packed {
    logic bypass_en;
    logic out_invert;
    logic resync;
    logic dual_edge_mode;
    logic oe_edge_fall;
    logic out_edge_fall;
    logic in_edge_fall;
    logic oe_reg_en;
    logic out_reg_en;
    logic in_reg_en;
  } icp_cell_ctrl_t;

  // Fast-pair options above the per-cell field.
  typedef struct packed {
    logic      full_rate;
    icp_dest_t bypass_dest;
    logic      serdes_en;
    logic      differential;
  } icp_fp_ext_t;

endpackage

// ### icp_sync.sv
`timescale 1ns/100ps
`default_nettype none

module icp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;

  // Two sync flops per bit plus a third; the second and third stages feed the edge compare.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edge pulses last one cycle of clk_i.
  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;
  assign fall_o  = ~sync_q & last_q;

endmodule

`default_nettype wire

// ### icp_io_cell.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RL1 - Dual-edge input: bit0 rising, bit1 falling sample.
// RL2 - Dual-edge output: bit0 rising, bit1 falling.
// RL3 - Deserializer: earliest bit lands on bit 0.
// RL4 - Serializer: bit 0 sent first, bit 3 last.
// RL5 - Delay step: direction 1 increments, 0 decrements.
// RL6 - Delay clear returns counter to reset value.
// RL7 - Core drives negative-leg enable equal to primary.
// RL8 - Transmit register clock times data and enable.
// RL9 - Receive register clock times input capture.
// RL10 - Transmit serial clock shifts the serializer.
// RL11 - Receive serial clock shifts the deserializer.
// RL12 - High-voltage tap feeds PLL reference only.
// RL13 - Fast tap routes to five clock destinations.
// RL14 - Drive enable optionally registered per cell.
// RL15 - Pair is two single pins or differential.
// RL16 - Differential uses only positive-resource core signals; the code still gates the N-leg enable with drive_enable_neg_leg_i.
// RL17 - Resync moves falling sample to rising edge.
// RL18 - Each register edge selectable, paths independent.
// RL19 - Serdes works only in full-rate clocking.
// RL20 - Dynamic delay: 64 steps, input path only.
// RL21 - Delay counter saturates at both ends.
module icp_io_cell
  import icp_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   tx_register_clock_i,
  input  wire logic                   rx_register_clock_i,
  input  wire logic                   tx_serial_clock_i,
  input  wire logic                   rx_serial_clock_i,
  input  wire logic [ICP_HV_W-1:0]    hv_out_i,
  input  wire logic                   hv_drive_enable_i,
  output logic      [ICP_HV_W-1:0]    hv_in_o,
  input  wire logic [ICP_FP_W-1:0]    fp_out_i,
  input  wire logic                   fp_drive_enable_i,
  input  wire logic                   drive_enable_neg_leg_i,
  input  wire logic                   fp_n_out_i,
  output logic      [ICP_FP_W-1:0]    fp_in_o,
  output logic                        fp_n_in_o,
  input  wire logic                   delay_step_enable_i,
  input  wire logic                   delay_step_direction_i,
  input  wire logic                   delay_count_clear_i,
  output logic      [ICP_DELAY_W-1:0] delay_count_o,
  input  wire logic                   hv_pad_i,
  output logic                        hv_pad_o,
  output logic                        hv_pad_oe_o,
  input  wire logic                   fp_p_pad_i,
  output logic                        fp_p_pad_o,
  output logic                        fp_p_pad_oe_o,
  input  wire logic                   fp_n_pad_i,
  output logic                        fp_n_pad_o,
  output logic                        fp_n_pad_oe_o,
  output logic                        hv_bypass_pll_ref_o,
  output logic      [ICP_DEST_N-1:0]  fp_bypass_tap_o
);

  logic [31:0]            hv_ctrl_q;
  logic [31:0]            fp_ctrl_q;
  logic [31:0]            rd_data_d;
  logic [31:0]            wb_dat_q;
  logic                   wb_ack_q;
  logic                   wr_fire;
  logic [ICP_SY_W-1:0]    sy_async;
  logic [ICP_SY_W-1:0]    sy_level;
  logic [ICP_SY_W-1:0]    sy_rise;
  logic [ICP_SY_W-1:0]    sy_fall;
  logic                   rx_rise;
  logic                   rx_fall;
  logic                   tx_rise;
  logic                   tx_fall;
  logic                   rxs_rise;
  logic                   txs_rise;
  icp_fp_ext_t            fp_ext;
  logic                   serdes_act;
  logic [ICP_DELAY_W-1:0] delay_q;
  logic [ICP_DELAY_STEPS-1:0] delay_line_q;
  logic                   fp_p_delayed;
  icp_cell_ctrl_t         cell_ctrl [ICP_CELLS];
  logic [1:0]             cell_out  [ICP_CELLS];
  logic                   cell_oe   [ICP_CELLS];
  logic                   cell_pad  [ICP_CELLS];
  logic [ICP_FP_W-1:0]    deser_q;
  logic [ICP_FP_W-1:0]    fp_in_q;
  logic [ICP_FP_W-1:0]    ser_word_q;
  logic [1:0]             ser_idx_q;
  logic                   ser_bit_q;
  logic                   fp_p_out_q;
  logic                   fp_p_oe_q;
  logic                   fp_n_out_q;
  logic                   fp_n_oe_q;
  logic                   fp_n_in_q;
  logic                   hv_tap_q;
  logic [ICP_DEST_N-1:0]  fp_tap_q;

  // Pad levels and the four cell clocks enter the clk_i domain here.
  assign sy_async[ICP_SY_RX_REG] = rx_register_clock_i;
  assign sy_async[ICP_SY_TX_REG] = tx_register_clock_i;
  assign sy_async[ICP_SY_RX_SER] = rx_serial_clock_i;
  assign sy_async[ICP_SY_TX_SER] = tx_serial_clock_i;
  assign sy_async[ICP_SY_HV_PAD] = hv_pad_i;
  assign sy_async[ICP_SY_FP_P]   = fp_p_pad_i;
  assign sy_async[ICP_SY_FP_N]   = fp_n_pad_i;

  icp_sync #(
    .WIDTH (ICP_SY_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (sy_async),
    .level_o (sy_level),
    .rise_o  (sy_rise),
    .fall_o  (sy_fall)
  );

  // Each clock gives its own edge events, so the paths stay independent.
  assign rx_rise  = sy_rise[ICP_SY_RX_REG]; // [RL9]
  assign rx_fall  = sy_fall[ICP_SY_RX_REG];
  assign tx_rise  = sy_rise[ICP_SY_TX_REG]; // [RL8]
  assign tx_fall  = sy_fall[ICP_SY_TX_REG];
  assign rxs_rise = sy_rise[ICP_SY_RX_SER]; // [RL11]
  assign txs_rise = sy_rise[ICP_SY_TX_SER]; // [RL10]

  // Wishbone write strobe fires on the edge where the master samples ack.
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_q;

  // Control registers with byte-lane writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv_ctrl_q <= ICP_HV_CTRL_RST;
      fp_ctrl_q <= ICP_FP_CTRL_RST;
    end else if (wr_fire) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          if (wb_adr_i == ICP_ADR_HV_CTRL) begin
            hv_ctrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
          if (wb_adr_i == ICP_ADR_FP_CTRL) begin
            fp_ctrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    rd_data_d = '0;
    case (wb_adr_i)
      ICP_ADR_HV_CTRL: rd_data_d = hv_ctrl_q;
      ICP_ADR_FP_CTRL: rd_data_d = fp_ctrl_q;
      ICP_ADR_STATUS: begin
        rd_data_d[ICP_ST_HV_IN_LSB +: ICP_HV_W]    = hv_in_o;
        rd_data_d[ICP_ST_FP_IN_LSB +: ICP_FP_W]    = fp_in_q;
        rd_data_d[ICP_ST_FP_N_BIT]                 = fp_n_in_q;
        rd_data_d[ICP_ST_DELAY_LSB +: ICP_DELAY_W] = delay_q;
      end
      default: rd_data_d = '0;
    endcase
  end

  // Ack comes one cycle after the request and drops the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= '0;
    end else begin
      wb_ack_q <= wb_cyc_i & wb_stb_i & ~wb_ack_q;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_q) begin
        wb_dat_q <= rd_data_d;
      end
    end
  end

  assign fp_ext     = icp_fp_ext_t'(fp_ctrl_q[ICP_FP_EXT_LSB +: ICP_FP_EXT_W]);
  assign serdes_act = fp_ext.serdes_en & fp_ext.full_rate; // [RL19]

  // Delay counter steps once per receive register clock rising edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delay_q <= ICP_DELAY_RST;
    end else if (delay_count_clear_i) begin
      delay_q <= ICP_DELAY_RST; // [RL6]
    end else if (rx_rise && delay_step_enable_i) begin
      if (delay_step_direction_i && delay_q != ICP_DELAY_MAX) begin
        delay_q <= delay_q + 6'h01; // [RL5] [RL21]
      end else if (!delay_step_direction_i && delay_q != ICP_DELAY_MIN) begin
        delay_q <= delay_q - 6'h01; // [RL5] [RL21]
      end
    end
  end

  // Tapped line delays only the positive input of the pair.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delay_line_q <= '0;
    end else begin
      delay_line_q <= {delay_line_q[ICP_DELAY_STEPS-2:0], sy_level[ICP_SY_FP_P]};
    end
  end

  assign fp_p_delayed = delay_line_q[delay_q]; // [RL20]

  // Inputs of the two general-purpose cells.
  assign cell_ctrl[ICP_CELL_HV] = icp_cell_ctrl_t'(hv_ctrl_q[ICP_CELL_CTRL_W-1:0]);
  assign cell_ctrl[ICP_CELL_FP] = icp_cell_ctrl_t'(fp_ctrl_q[ICP_CELL_CTRL_W-1:0]);
  assign cell_out[ICP_CELL_HV]  = hv_out_i;
  assign cell_out[ICP_CELL_FP]  = fp_out_i[1:0];
  assign cell_oe[ICP_CELL_HV]   = hv_drive_enable_i;
  assign cell_oe[ICP_CELL_FP]   = fp_drive_enable_i;
  assign cell_pad[ICP_CELL_HV]  = sy_level[ICP_SY_HV_PAD];
  assign cell_pad[ICP_CELL_FP]  = fp_p_delayed;

  for (genvar c = 0; c < ICP_CELLS; c++) begin : g_cell
    logic [1:0] in_q;
    logic       hold_q;
    logic       pout_q;
    logic       oe_q;
    logic       in_edge;
    logic       out_edge;
    logic       oe_edge;

    // Edge choice is per register, input and output chosen apart.
    assign in_edge  = cell_ctrl[c].in_edge_fall ? rx_fall : rx_rise; // [RL18]
    assign out_edge = cell_ctrl[c].out_edge_fall ? tx_fall : tx_rise; // [RL18]
    assign oe_edge  = cell_ctrl[c].oe_edge_fall ? tx_fall : tx_rise; // [RL18]

    // Input capture; dual-edge keeps rising on bit 0, falling on bit 1.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        in_q   <= 2'h0;
        hold_q <= 1'b0;
      end else if (!cell_ctrl[c].in_reg_en) begin
        in_q <= {1'b0, cell_pad[c]};
      end else if (cell_ctrl[c].dual_edge_mode) begin
        if (cell_ctrl[c].resync) begin
          if (rx_fall) begin
            hold_q <= cell_pad[c];
          end
          if (rx_rise) begin
            in_q <= {hold_q, cell_pad[c]}; // [RL17] [RL1]
          end
        end else begin
          if (rx_rise) begin
            in_q[0] <= cell_pad[c]; // [RL1]
          end
          if (rx_fall) begin
            in_q[1] <= cell_pad[c]; // [RL1]
          end
        end
      end else if (in_edge) begin
        in_q <= {1'b0, cell_pad[c]};
      end
    end

    // Output path; dual-edge merges both bits into one stream.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pout_q <= 1'b0;
      end else if (cell_ctrl[c].dual_edge_mode) begin
        if (tx_rise) begin
          pout_q <= cell_out[c][0] ^ cell_ctrl[c].out_invert; // [RL2] [RL8]
        end else if (tx_fall) begin
          pout_q <= cell_out[c][1] ^ cell_ctrl[c].out_invert; // [RL2] [RL8]
        end
      end else if (!cell_ctrl[c].out_reg_en) begin
        pout_q <= cell_out[c][0];
      end else if (out_edge) begin
        pout_q <= cell_out[c][0] ^ cell_ctrl[c].out_invert;
      end
    end

    // Drive enable, registered on the transmit clock when asked.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        oe_q <= 1'b0;
      end else if (!cell_ctrl[c].oe_reg_en || oe_edge) begin
        oe_q <= cell_oe[c]; // [RL14] [RL8]
      end
    end
  end

  // Deserializer shifts toward bit 0, so the oldest bit ends there.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deser_q <= '0;
    end else if (rxs_rise) begin
      deser_q <= {fp_p_delayed, deser_q[ICP_FP_W-1:1]}; // [RL11] [RL3]
    end
  end

  // Core input word of the pair, serial or plain.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fp_in_q <= '0;
    end else if (!serdes_act) begin
      fp_in_q <= {2'h0, g_cell[ICP_CELL_FP].in_q};
    end else if (rx_rise) begin
      fp_in_q <= rxs_rise ? {fp_p_delayed, deser_q[ICP_FP_W-1:1]} : deser_q; // [RL3] [RL9]
    end
  end

  // Serializer loads on the register clock and sends bit 0 first.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_word_q <= '0;
      ser_idx_q  <= ICP_SER_FIRST;
      ser_bit_q  <= 1'b0;
    end else if (tx_rise) begin
      ser_word_q <= fp_out_i; // [RL8]
      if (txs_rise) begin
        ser_bit_q <= fp_out_i[0]; // [RL4]
        ser_idx_q <= ICP_SER_NEXT;
      end else begin
        ser_idx_q <= ICP_SER_FIRST;
      end
    end else if (txs_rise) begin
      ser_bit_q <= ser_word_q[ser_idx_q]; // [RL4] [RL10]
      ser_idx_q <= ser_idx_q + ICP_SER_NEXT;
    end
  end

  // Pad drive of the pair, as two pins or as one differential pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fp_p_out_q <= 1'b0;
      fp_p_oe_q  <= 1'b0;
      fp_n_out_q <= 1'b0;
      fp_n_oe_q  <= 1'b0;
      fp_n_in_q  <= 1'b0;
    end else begin
      fp_p_out_q <= serdes_act ? ser_bit_q : g_cell[ICP_CELL_FP].pout_q;
      fp_p_oe_q  <= g_cell[ICP_CELL_FP].oe_q;
      if (fp_ext.differential) begin
        fp_n_out_q <= serdes_act ? ~ser_bit_q : ~g_cell[ICP_CELL_FP].pout_q; // [RL15] [RL16]
        fp_n_oe_q  <= g_cell[ICP_CELL_FP].oe_q & drive_enable_neg_leg_i; // [RL7]
        fp_n_in_q  <= 1'b0;
      end else begin
        fp_n_out_q <= fp_n_out_i; // [RL15]
        fp_n_oe_q  <= drive_enable_neg_leg_i;
        fp_n_in_q  <= sy_level[ICP_SY_FP_N];
      end
    end
  end

  // Unregistered taps bypass the capture registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv_tap_q <= 1'b0;
      fp_tap_q <= '0;
    end else begin
      hv_tap_q <= cell_ctrl[ICP_CELL_HV].bypass_en & sy_level[ICP_SY_HV_PAD]; // [RL12]
      for (int d = 0; d < ICP_DEST_N; d++) begin
        fp_tap_q[d] <= cell_ctrl[ICP_CELL_FP].bypass_en
                       & (fp_ext.bypass_dest == icp_dest_t'(d))
                       & sy_level[ICP_SY_FP_P]; // [RL13]
      end
    end
  end

  // Every output is a flop.
  assign wb_dat_o            = wb_dat_q;
  assign wb_ack_o            = wb_ack_q;
  assign hv_in_o             = g_cell[ICP_CELL_HV].in_q;
  assign hv_pad_o            = g_cell[ICP_CELL_HV].pout_q;
  assign hv_pad_oe_o         = g_cell[ICP_CELL_HV].oe_q;
  assign fp_in_o             = fp_in_q;
  assign fp_n_in_o           = fp_n_in_q;
  assign delay_count_o       = delay_q;
  assign fp_p_pad_o          = fp_p_out_q;
  assign fp_p_pad_oe_o       = fp_p_oe_q;
  assign fp_n_pad_o          = fp_n_out_q;
  assign fp_n_pad_oe_o       = fp_n_oe_q;
  assign hv_bypass_pll_ref_o = hv_tap_q;
  assign fp_bypass_tap_o     = fp_tap_q;

endmodule

`default_nettype wire

// ### icp_io_cell_props.sv
`timescale 1ns/100ps
`default_nettype none
module icp_io_cell_props
  import icp_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_ack_o,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   delay_step_enable_i,
  input wire logic                   delay_step_direction_i,
  input wire logic                   delay_count_clear_i,
  input wire logic [ICP_DELAY_W-1:0] delay_count_o,
  input wire logic [ICP_DEST_N-1:0]  fp_bypass_tap_o
);
  logic [5:0] dly_q;
  logic       clr_q;
  logic       en_q;
  logic       dir_q;

  // All checks run on the system clock and rest while reset is high.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Delay controls and count as they stood one cycle earlier.
  always_ff @(posedge clk_i) begin
    dly_q <= delay_count_o;
    clr_q <= delay_count_clear_i;
    en_q  <= delay_step_enable_i;
    dir_q <= delay_step_direction_i;
  end

  // A taken request is answered on the next edge by a single-cycle ack.
  a_ack_on_time:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow the request");
  a_ack_one_cycle:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_has_cause:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_rdata_held:
    assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved outside an ack");

  // The delay counter moves one step at a time, never wraps, and clears at once.
  a_clear_to_rst:
    assert property (delay_count_clear_i |=> delay_count_o == ICP_DELAY_RST)
    else $error("delay count not cleared");
  a_step_unit:
    assert property (delay_count_o != dly_q && !clr_q |->
      (dly_q != ICP_DELAY_MAX && delay_count_o == dly_q + 6'h01) ||
      (dly_q != ICP_DELAY_MIN && delay_count_o == dly_q - 6'h01))
    else $error("delay count jumped or wrapped");
  a_step_up_dir:
    assert property (!clr_q && delay_count_o > dly_q |-> en_q && dir_q)
    else $error("delay rose without an up step");
  a_step_down_dir:
    assert property (!clr_q && delay_count_o < dly_q |-> en_q && !dir_q)
    else $error("delay fell without a down step");

  // The fast-pair tap reaches at most one destination.
  a_tap_one_hot:
    assert property ($onehot0(fp_bypass_tap_o))
    else $error("tap drives several destinations");
endmodule

bind icp_io_cell icp_io_cell_props chk_u (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .delay_step_enable_i,
  .delay_step_direction_i, .delay_count_clear_i, .delay_count_o, .fp_bypass_tap_o
);
`default_nettype wire

// ### icp_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module icp_core_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic fp_drive_enable_i,
  output logic      tx_register_clock_o,
  output logic      rx_register_clock_o,
  output logic      tx_serial_clock_o,
  output logic      rx_serial_clock_o,
  output logic      drive_enable_neg_leg_o,
  output logic      fp_n_out_o
);
  logic [4:0] cnt_q = 5'h00;

  // Free-running phase counter; one register period spans 32 system clocks.
  always_ff @(posedge clk_i) begin
    cnt_q <= rst_i ? 5'h00 : cnt_q + 5'h01;
  end

  // Register clocks are high in the first half of the period.
  assign tx_register_clock_o = ~cnt_q[4];
  assign rx_register_clock_o = ~cnt_q[4];
  // Serial clocks give one full-rate bit per rise, four per register period.
  assign tx_serial_clock_o = ~cnt_q[2];
  assign rx_serial_clock_o = ~cnt_q[2];
  // The negative-leg enable is a copy of the primary enable.
  assign drive_enable_neg_leg_o = fp_drive_enable_i;
  // The N data leg is unused in differential mode, so it carries a moving pattern.
  assign fp_n_out_o = cnt_q[0];
endmodule
`default_nettype wire

// ### tb_icp_io_cell.sv
`timescale 1ns/100ps
`default_nettype none
module tb_icp_io_cell import icp_pkg::*;;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf, fp_out_i = 4'h0, fp_in_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic [1:0]  hv_out_i = 2'h0, hv_in_o;
  logic        hv_drive_enable_i = 1'b1, fp_drive_enable_i = 1'b1, hv_pad_i = 1'b0;
  logic        fp_p_pad_i = 1'b0, fp_n_pad_i = 1'b0, delay_step_enable_i = 1'b0;
  logic        delay_step_direction_i = 1'b0, delay_count_clear_i = 1'b0, wb_ack_o;
  logic        tx_register_clock_i, rx_register_clock_i, tx_serial_clock_i, rx_serial_clock_i;
  logic        drive_enable_neg_leg_i, fp_n_out_i, fp_n_in_o, hv_pad_o, hv_pad_oe_o;
  logic        fp_p_pad_o, fp_p_pad_oe_o, fp_n_pad_o, fp_n_pad_oe_o, hv_bypass_pll_ref_o;
  logic [5:0]  delay_count_o;
  logic [4:0]  fp_bypass_tap_o;
  int          n_errors = 0, num_checks = 0, ncyc = 0;

  icp_io_cell dut_u (.*);
  icp_core_model model_u (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .fp_drive_enable_i      (fp_drive_enable_i),
    .tx_register_clock_o    (tx_register_clock_i),
    .rx_register_clock_o    (rx_register_clock_i),
    .tx_serial_clock_o      (tx_serial_clock_i),
    .rx_serial_clock_o      (rx_serial_clock_i),
    .drive_enable_neg_leg_o (drive_enable_neg_leg_i),
    .fp_n_out_o             (fp_n_out_i)
  );

  // System clock of 50 ns period.
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One classic Wishbone cycle; read data lands in r at the ack edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    chk("wb_ack_o wait", 2, n);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    cy(1);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  always @(posedge clk_i) begin
    ncyc++;
    if (ncyc == 20000) begin
      n_errors++;
      $display("[ERR] run_cycles expected below 20000 seen 20000");
      test_done();
    end
  end

  initial begin
    logic       a = 1'b0, b = 1'b0, bp = 1'b0;
    logic [1:0] o = 2'h0;
    logic [3:0] w = 4'h0, rw = 4'h0, rp = 4'h0;
    int         m, i, k, d;
    r = $urandom(32'h9b3c);
    cy(6);
    rst_i <= 1'b0;
    wb(1'b0, ICP_ADR_HV_CTRL, 32'h0);
    chk("hv_ctrl", ICP_HV_CTRL_RST, r);
    wb(1'b0, ICP_ADR_FP_CTRL, 32'h0);
    chk("fp_ctrl", ICP_FP_CTRL_RST, r);
    wb(1'b1, 8'h0c, 32'hffffffff);
    wb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, r);
    wb(1'b1, ICP_ADR_STATUS, 32'hffffffff);
    wb(1'b0, ICP_ADR_STATUS, 32'h0);
    chk("status delay", ICP_DELAY_RST, r[21:16]);
    d = $urandom & 32'h3ff;
    wb(1'b1, ICP_ADR_HV_CTRL, d);
    wb(1'b0, ICP_ADR_HV_CTRL, 32'h0);
    chk("hv_ctrl rw", d, r & 32'h3ff);
    // Dual-edge pad traffic, plain then resynchronised.
    for (m = 0; m < 2; m++) begin
      wb(1'b1, ICP_ADR_HV_CTRL, (m == 1) ? 32'h1c7 : 32'h47);
      @(posedge rx_register_clock_i);
      for (i = 0; i < 8; i++) begin
        cy(8);
        if (i > 0) begin
          chk("hv_pad_o rise", o[0] ^ m[0], hv_pad_o);
          chk("hv_in_o rise", {bp, a}, hv_in_o);
          chk("hv_pad_oe_o", a, hv_pad_oe_o);
        end
        hv_pad_i <= b;
        cy(16);
        if (i > 0) begin
          chk("hv_pad_o fall", o[1] ^ m[0], hv_pad_o);
          chk("hv_in_o fall", {((m == 1) ? bp : b), a}, hv_in_o);
        end
        bp = b;
        o = 2'($urandom);
        a = 1'($urandom);
        b = 1'($urandom);
        hv_out_i <= o;
        hv_pad_i <= a;
        hv_drive_enable_i <= a;
        cy(8);
      end
    end
    // Differential pair with the 1:4 serializer and deserializer.
    wb(1'b1, ICP_ADR_FP_CTRL, 32'h8c03);
    @(posedge rx_register_clock_i);
    for (i = 0; i < 10; i++) begin
      for (k = 0; k < 4; k++) begin
        cy(4);
        fp_p_pad_i <= rw[k];
        cy(3);
        if (i > 1) begin
          chk("fp_p_pad_o", w[k], fp_p_pad_o);
          chk("fp_n_pad_o", !w[k], fp_n_pad_o);
          chk("fp_n_pad_oe_o", w[0], fp_n_pad_oe_o);
          chk("fp_n_in_o", 0, fp_n_in_o);
        end
        if (i > 1 && k == 1) chk("fp_in_o", rp, fp_in_o);
        if (k == 3) begin
          rp = rw;
          rw = 4'($urandom);
          w = 4'($urandom);
          fp_out_i <= w;
          fp_drive_enable_i <= w[0];
        end
        cy(1);
      end
    end
    // Dynamic delay: climb to the top, step down, hold, clear, floor.
    delay_step_direction_i <= 1'b1;
    delay_step_enable_i <= 1'b1;
    cy(66 * 32);
    chk("delay_count_o top", ICP_DELAY_MAX, delay_count_o);
    wb(1'b0, ICP_ADR_STATUS, 32'h0);
    chk("status delay", ICP_DELAY_MAX, r[21:16]);
    @(posedge rx_register_clock_i);
    cy(16);
    delay_step_direction_i <= 1'b0;
    cy(160);
    chk("delay_count_o down", ICP_DELAY_MAX - 6'h05, delay_count_o);
    delay_step_enable_i <= 1'b0;
    cy(64);
    chk("delay_count_o hold", ICP_DELAY_MAX - 6'h05, delay_count_o);
    delay_count_clear_i <= 1'b1;
    cy(1);
    delay_count_clear_i <= 1'b0;
    cy(2);
    chk("delay_count_o clear", ICP_DELAY_RST, delay_count_o);
    delay_step_enable_i <= 1'b1;
    cy(96);
    chk("delay_count_o floor", ICP_DELAY_MIN, delay_count_o);
    delay_step_enable_i <= 1'b0;
    // Unregistered taps to each destination.
    for (d = 0; d < ICP_DEST_N; d++) begin
      wb(1'b1, ICP_ADR_FP_CTRL, 32'h8200 | (d << 12));
      fp_p_pad_i <= 1'b1;
      cy(6);
      chk("fp_bypass_tap_o", 1 << d, fp_bypass_tap_o);
    end
    wb(1'b1, ICP_ADR_HV_CTRL, 32'h200);
    for (d = 0; d < 2; d++) begin
      hv_pad_i <= d[0];
      cy(6);
      chk("hv_bypass_pll_ref_o", d[0], hv_bypass_pll_ref_o);
    end
    test_done();
  end
endmodule
`default_nettype wire
